//--- design/pstu_top.sv
// software timer bank with accumulators behind an avalon-mm slave
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
//
// Operation
// - one-shot: rise starts, low clears, running=1
// - lengthened: rise starts, low ignored, running=1
// - on-delay: rise starts, low clears, expired&high
// - latched on-delay: expiry sets status until reset or a new start edge
// - off-delay: fall starts, high holds initial
// - off-delay status: input high or running
// - reset with input high holds initial until the next start
// - status zero when reset-held or never started
// - start operations act on edges only
// - start takes time word from operand register
// - base code selects 10ms,100ms,1s,10s unit
// - decrement once per unit, stop at zero
// - interval may be one unit short
// - start edge while running reloads, restarts
// - timers count independently of command flow
// - raw load puts remaining time into operand
// - scan returns mode-dependent status
// - bcd load converts remaining time to BCD
// - load shifts operand into second accumulator
module pstu_top
   import pstu_pkg::*;
#(
   parameter int unsigned P_TICK_CYC = BASE_TICK_CYC
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest
);
   typedef struct packed {
      pstu_fsm_t        fsm;
      logic [15:0]      acc1;
      logic [15:0]      acc2;
      logic             scan;
      logic [31:0]      rdata;
      logic             rd_ack;
      logic             cmd_ack;
      logic [CMD_W-1:0] cmd;
      logic             is_cmd;
      logic [IDX_W-1:0] ptr;
      logic [IDX_W-1:0] idx;
      logic             sweep;
      logic [NBASE-1:0] mask;
      logic [NBASE-1:0] pend;
      logic [31:0]      pre;
      logic [2:0][3:0]  dec;
   } pstu_state_t;

   pstu_state_t      s;
   pstu_state_t      next_s;
   pstu_entry_t      ent;
   pstu_entry_t      wdata;
   logic             we;
   logic [IDX_W-1:0] waddr;
   logic [NBASE-1:0] ticks;
   logic             cmd_req;
   pstu_op_t         op;
   logic             logic_result_bit;
   logic             rise;
   logic             fall;
   logic [9:0]       tw_cnt;
   logic [1:0]       tw_base;

   pstu_mem u_mem (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_we    (we),
      .i_waddr (waddr),
      .i_wdata (wdata),
      .i_raddr (s.ptr),
      .o_rdata (ent)
   );

   assign cmd_req           = i_avs_write && (i_avs_address == ADR_CMD);
   assign o_avs_waitrequest = (i_avs_read && !s.rd_ack) || (cmd_req && !s.cmd_ack);
   assign o_avs_readdata    = s.rdata;
   assign op      = pstu_op_t'(s.cmd[CMD_OP_LSB +: 4]);
   assign logic_result_bit     = s.cmd[CMD_RLO_BIT];
   assign rise    = logic_result_bit && !ent.rlo_prev;
   assign fall    = !logic_result_bit && ent.rlo_prev;
   assign tw_cnt  = bcd2bin(s.acc1[TW_BCD_MSB:0]);
   assign tw_base = s.acc1[TW_BASE_LSB +: 2];

   always_comb begin
      pstu_entry_t w;
      w      = ent;
      next_s = s;
      we     = 1'b0;
      waddr  = s.ptr;
      next_s.rd_ack  = 1'b0;
      next_s.cmd_ack = 1'b0;

      // shared prescaler: phase is common to all timers, hence up to one unit short
      ticks[0] = (s.pre == (P_TICK_CYC - 1));
      next_s.pre = ticks[0] ? 32'h0 : s.pre + 32'h1;
      for (int k = 1; k < NBASE; k++) begin
         ticks[k] = ticks[k-1] && (s.dec[k-1] == DECADE_LAST);
         if (ticks[k-1]) begin
            next_s.dec[k-1] = (s.dec[k-1] == DECADE_LAST) ? 4'h0 : s.dec[k-1] + 4'h1;
         end
      end
      next_s.pend = s.pend | ticks;

      // bus side reads and direct operand loads
      if (i_avs_read && !s.rd_ack) begin
         next_s.rd_ack = 1'b1;
         unique case (i_avs_address)
            ADR_CMD:  next_s.rdata = {{(32-CMD_W){1'b0}}, s.cmd};
            ADR_ACC1: next_s.rdata = {16'h0000, s.acc1};
            ADR_ACC2: next_s.rdata = {16'h0000, s.acc2};
            ADR_SCAN: next_s.rdata = {31'h00000000, s.scan};
            default:  next_s.rdata = 32'h00000000;
         endcase
      end
      if (i_avs_write && (i_avs_address == ADR_ACC1)) begin
         next_s.acc2 = s.acc1;
         next_s.acc1[7:0]  = i_avs_byteenable[0] ? i_avs_writedata[7:0]  : s.acc1[7:0];
         next_s.acc1[15:8] = i_avs_byteenable[1] ? i_avs_writedata[15:8] : s.acc1[15:8];
      end

      unique case (s.fsm)
         ST_INIT: begin
            we    = 1'b1;
            waddr = s.idx;
            w     = '0;
            next_s.idx = s.idx + 7'h01;
            if (s.idx == 7'(NTIMER - 1)) begin
               next_s.fsm = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (cmd_req && !s.cmd_ack) begin
               next_s.cmd    = i_avs_writedata[CMD_W-1:0];
               next_s.ptr    = i_avs_writedata[CMD_IDX_LSB +: IDX_W];
               next_s.is_cmd = 1'b1;
               next_s.fsm    = ST_RD;
            end else if (s.sweep) begin
               next_s.ptr    = s.idx;
               next_s.is_cmd = 1'b0;
               next_s.fsm    = ST_RD;
            end else if (s.pend != '0) begin
               // new ticks in this cycle stay pending, so set wins over clear
               next_s.sweep = 1'b1;
               next_s.mask  = s.pend;
               next_s.pend  = ticks;
               next_s.idx   = '0;
            end
         end
         ST_RD: begin
            next_s.fsm = ST_MOD;
         end
         ST_MOD: begin
            next_s.fsm = ST_IDLE;
            if (!s.is_cmd) begin
               we = 1'b1;
               // background countdown, independent of the command stream
               if (ent.run && s.mask[ent.base]) begin
                  if (ent.count <= CNT_ONE) begin
                     w.count = '0;
                     w.run   = 1'b0;
                     w.done  = 1'b1;
                  end else begin
                     w.count = ent.count - CNT_ONE;
                  end
               end
               next_s.idx = s.idx + 7'h01;
               if (s.idx == 7'(NTIMER - 1)) begin
                  next_s.sweep = 1'b0;
               end
            end else begin
               we = 1'b1;
               next_s.cmd_ack = 1'b1;
               if (op inside {OP_ONE_SHOT, OP_LENGTHEN, OP_ON_DELAY, OP_LATCHED, OP_OFF_DELAY}) begin
                  w.rlo_prev = logic_result_bit;
               end
               unique case (op)
                  OP_ONE_SHOT: begin
                     w.mode = MODE_ONE_SHOT;
                     if (rise) begin
                        w = start_entry(w);
                     end else if (!logic_result_bit) begin
                        w.count = '0;
                        w.run   = 1'b0;
                     end
                  end
                  OP_LENGTHEN: begin
                     w.mode = MODE_LENGTHEN;
                     if (rise) begin
                        w = start_entry(w);
                     end
                  end
                  OP_ON_DELAY: begin
                     w.mode = MODE_ON_DELAY;
                     if (rise) begin
                        w = start_entry(w);
                     end else if (!logic_result_bit) begin
                        w.count = '0;
                        w.run   = 1'b0;
                        w.done  = 1'b0;
                     end
                  end
                  OP_LATCHED: begin
                     w.mode = MODE_LATCHED;
                     if (rise) begin
                        w = start_entry(w);
                     end
                  end
                  OP_OFF_DELAY: begin
                     w.mode = MODE_OFF_DELAY;
                     if (fall) begin
                        w = start_entry(w);
                     end else if (logic_result_bit) begin
                        w = start_entry(w);
                        w.run = 1'b0;
                     end
                  end
                  OP_RESET: begin
                     if (logic_result_bit) begin
                        w.count = ent.init_cnt;
                        w.run   = 1'b0;
                        w.done  = 1'b0;
                        w.held  = 1'b1;
                     end
                  end
                  OP_LOAD_RAW: begin
                     next_s.acc2 = s.acc1;
                     next_s.acc1 = {2'b00, ent.base, 2'b00, ent.count};
                  end
                  OP_LOAD_BCD: begin
                     next_s.acc2 = s.acc1;
                     next_s.acc1 = {2'b00, ent.base, bin2bcd(ent.count)};
                  end
                  OP_SCAN: begin
                     next_s.scan = status_of(ent);
                  end
                  OP_NOP: begin
                     w = ent;
                  end
                  default: begin
                     w = ent;
                  end
               endcase
            end
         end
      endcase
      wdata = w;
   end

   // load the time word and restart the countdown
   function automatic pstu_entry_t start_entry(input pstu_entry_t e);
      pstu_entry_t r;
      r          = e;
      r.count    = tw_cnt;
      r.init_cnt = tw_cnt;
      r.base     = tw_base;
      r.run      = 1'b1;
      r.done     = 1'b0;
      r.held     = 1'b0;
      start_entry = r;
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s     <= '0;
         s.fsm <= ST_INIT;
      end else begin
         s <= next_s;
      end
   end

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   logic cmd_mod;
   assign cmd_mod = (s.fsm == ST_MOD) && s.is_cmd;

   property p_one_shot_low;
      cmd_mod && (op == OP_ONE_SHOT) && !logic_result_bit |-> we && !wdata.run && (wdata.count == '0);
   endproperty
   a_one_shot_low: assert property (p_one_shot_low) else $error("one-shot low did not clear");

   property p_lengthen_keep;
      cmd_mod && (op == OP_LENGTHEN) && !rise |-> (wdata.count == ent.count) && (wdata.run == ent.run);
   endproperty
   a_lengthen_keep: assert property (p_lengthen_keep) else $error("lengthened timer disturbed");

   property p_on_delay_low;
      cmd_mod && (op == OP_ON_DELAY) && !logic_result_bit |-> we && !wdata.done && !wdata.run && (wdata.count == '0);
   endproperty
   a_on_delay_low: assert property (p_on_delay_low) else $error("on-delay low kept expiry");

   property p_latched_keep;
      cmd_mod && (op == OP_LATCHED) && !rise |-> (wdata.done == ent.done);
   endproperty
   a_latched_keep: assert property (p_latched_keep) else $error("latched expiry lost");

   property p_off_delay_hold;
      cmd_mod && (op == OP_OFF_DELAY) && logic_result_bit |-> !wdata.run && (wdata.count == tw_cnt) && (wdata.base == tw_base);
   endproperty
   a_off_delay_hold: assert property (p_off_delay_hold) else $error("off-delay not held");

   property p_reset_effect;
      cmd_mod && (op == OP_RESET) |-> logic_result_bit ? (wdata.held && !wdata.run && wdata.count == ent.init_cnt)
                                          : (wdata == ent);
   endproperty
   a_reset_effect: assert property (p_reset_effect) else $error("reset effect wrong");

   property p_scan_held;
      cmd_mod && (op == OP_SCAN) && ent.held |=> (s.scan == 1'b0);
   endproperty
   a_scan_held: assert property (p_scan_held) else $error("held timer scanned as set");

   property p_start_load;
      cmd_mod && rise && (op inside {OP_ONE_SHOT, OP_LENGTHEN, OP_ON_DELAY, OP_LATCHED})
         |-> wdata.run && (wdata.count == tw_cnt) && (wdata.base == s.acc1[TW_BASE_LSB +: 2]);
   endproperty
   a_start_load: assert property (p_start_load) else $error("start did not load time word");

   property p_decrement;
      (s.fsm == ST_MOD) && !s.is_cmd && ent.run && s.mask[ent.base] && (ent.count > CNT_ONE)
         |-> (wdata.count == ent.count - CNT_ONE) && wdata.run;
   endproperty
   a_decrement: assert property (p_decrement) else $error("countdown decrement wrong");

   property p_load_shift;
      cmd_mod && (op inside {OP_LOAD_RAW, OP_LOAD_BCD}) |=> (s.acc2 == $past(s.acc1));
   endproperty
   a_load_shift: assert property (p_load_shift) else $error("second accumulator not shifted");

   property p_cmd_answer;
      (s.fsm == ST_IDLE) && cmd_req && !s.cmd_ack |-> ##3 !o_avs_waitrequest;
   endproperty
   a_cmd_answer: assert property (p_cmd_answer) else $error("command answer late");

   c_expiry: cover property ((s.fsm == ST_MOD) && !s.is_cmd && ent.run && s.mask[ent.base] && ent.count <= CNT_ONE);
   c_restart: cover property (cmd_mod && rise && ent.run);
   c_off_start: cover property (cmd_mod && (op == OP_OFF_DELAY) && fall);
   c_bcd_load: cover property (cmd_mod && (op == OP_LOAD_BCD));
endmodule

//--- design/pstu_pkg.sv
// constants, types and helpers shared by the software timer unit
package pstu_pkg;
   localparam int NTIMER      = 128;
   localparam int IDX_W       = 7;
   localparam int CLK_HZ      = 200_000_000;
   localparam int BASE_UNIT_US = 10_000;
   localparam int BASE_TICK_CYC = BASE_UNIT_US * (CLK_HZ / 1_000_000);
   localparam int NBASE       = 4;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam logic [3:0] ADR_CMD  = 4'h0;
   localparam logic [3:0] ADR_ACC1 = 4'h4;
   localparam logic [3:0] ADR_ACC2 = 4'h8;
   localparam logic [3:0] ADR_SCAN = 4'hC;
   localparam int CMD_IDX_LSB = 0;
   localparam int CMD_OP_LSB  = 8;
   localparam int CMD_RLO_BIT = 12;
   localparam int CMD_W       = 13;
   localparam int TW_BCD_MSB  = 11;
   localparam int TW_BASE_LSB = 12;
   localparam logic [9:0] CNT_ONE = 10'h001;

   typedef enum logic [3:0] {
      OP_NOP      = 4'b0000,
      OP_ONE_SHOT = 4'b0001,
      OP_LENGTHEN = 4'b0010,
      OP_ON_DELAY = 4'b0011,
      OP_LATCHED  = 4'b0100,
      OP_OFF_DELAY = 4'b0101,
      OP_RESET    = 4'b0110,
      OP_LOAD_RAW = 4'b0111,
      OP_LOAD_BCD = 4'b1000,
      OP_SCAN     = 4'b1001
   } pstu_op_t;

   typedef enum logic [2:0] {
      MODE_NONE      = 3'b000,
      MODE_ONE_SHOT  = 3'b001,
      MODE_LENGTHEN  = 3'b010,
      MODE_ON_DELAY  = 3'b011,
      MODE_LATCHED   = 3'b100,
      MODE_OFF_DELAY = 3'b101
   } pstu_mode_t;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_RD   = 2'b10,
      ST_MOD  = 2'b11
   } pstu_fsm_t;

   typedef struct packed {
      logic [9:0] count;
      logic [1:0] base;
      logic [9:0] init_cnt;
      pstu_mode_t mode;
      logic       run;
      logic       done;
      logic       rlo_prev;
      logic       held;
   } pstu_entry_t;

   function automatic logic [9:0] bcd2bin(input logic [11:0] b);
      bcd2bin = 10'({6'h00, b[11:8]} * 10'h064 + {6'h00, b[7:4]} * 10'h00A + {6'h00, b[3:0]});
   endfunction

   function automatic logic [11:0] bin2bcd(input logic [9:0] v);
      logic [9:0] h;
      logic [9:0] t;
      h = v / 10'h064;
      t = (v % 10'h064) / 10'h00A;
      bin2bcd = {h[3:0], t[3:0], 4'((v % 10'h00A))};
   endfunction

   function automatic logic status_of(input pstu_entry_t e);
      logic r;
      r = 1'b0;
      if (!e.held) begin
         unique case (e.mode)
            MODE_NONE:      r = 1'b0;
            MODE_ONE_SHOT:  r = e.run;
            MODE_LENGTHEN:  r = e.run;
            MODE_ON_DELAY:  r = e.done & e.rlo_prev;
            MODE_LATCHED:   r = e.done;
            MODE_OFF_DELAY: r = e.rlo_prev | e.run;
            default:        r = 1'b0;
         endcase
      end
      status_of = r;
   endfunction
endpackage

//--- design/pstu_mem.sv
// timer entry store with registered read data
`timescale 1ns/1ps
module pstu_mem
   import pstu_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_we,
   input  wire logic [IDX_W-1:0]  i_waddr,
   input  wire pstu_entry_t       i_wdata,
   input  wire logic [IDX_W-1:0]  i_raddr,
   output pstu_entry_t            o_rdata
);
   pstu_entry_t mem [NTIMER];

   // array itself is not reset; the owner clears it after reset
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

//--- sim/pstu_host.sv
// avalon-mm master standing in for the program-scanning core
`timescale 1ns/1ps
module pstu_host (
   input  wire logic        i_clk,
   input  wire logic        i_waitrequest,
   input  wire logic [31:0] i_readdata,
   output logic [3:0]       o_address,
   output logic             o_read,
   output logic             o_write,
   output logic [31:0]      o_writedata,
   output logic [3:0]       o_byteenable
);
   initial begin
      o_address    = 4'h0;
      o_read       = 1'b0;
      o_write      = 1'b0;
      o_writedata  = 32'h0;
      o_byteenable = 4'hF;
   end

   // request held whole until waitrequest is seen low at an edge
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
      @(posedge i_clk);
      o_address    <= a;
      o_read       <= ~w;
      o_write      <= w;
      o_writedata  <= d;
      o_byteenable <= be;
      do
         @(posedge i_clk);
      while (i_waitrequest !== 1'b0);
      q = i_readdata;
      o_read  <= 1'b0;
      o_write <= 1'b0;
   endtask
endmodule

//--- sim/test_plc_software_timer_unit.sv
// self-checking bench for the software timer unit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_plc_software_timer_unit;
   import pstu_pkg::*;
   // short unit so a 10 ms unit is 500 cycles, longer than one sweep
   localparam int TICK  = 500;
   localparam int LIMIT = 40000;
   logic        i_clk   = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cycles      = 0;
   logic [31:0] lfsr        = 32'h00016ACA;
   logic [31:0] q;
   logic [15:0] w1;
   logic [31:0] rv;
   logic [11:0] dg;

   always #2.5 i_clk = ~i_clk;

   pstu_host host (.i_clk(i_clk), .i_waitrequest(avs_waitrequest), .i_readdata(avs_readdata),
      .o_address(avs_address), .o_read(avs_read), .o_write(avs_write),
      .o_writedata(avs_writedata), .o_byteenable(avs_byteenable));

   pstu_top #(.P_TICK_CYC(TICK)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h000000C5 : 32'h0);
      return lfsr;
   endfunction

   // top two bits random: the unit must not look at them
   function automatic logic [15:0] tw(input logic [11:0] b, input logic [1:0] base);
      logic [31:0] r;
      r = rnd();
      return {r[1:0], base, b};
   endfunction

   task automatic cmd(input pstu_op_t op, input logic [6:0] idx, input logic logic_result_bit);
      host.xfer(1'b1, ADR_CMD, {19'h00000, logic_result_bit, op, 1'b0, idx}, 4'hF, q);
   endtask

   task automatic load(input logic [15:0] w);
      host.xfer(1'b1, ADR_ACC1, {16'h0000, w}, 4'hF, q);
   endtask

   task automatic rd(input logic [3:0] a);
      host.xfer(1'b0, a, 32'h0, 4'hF, q);
   endtask

   task automatic st(input logic [6:0] idx, input logic e);
      cmd(OP_SCAN, idx, 1'b0);
      rd(ADR_SCAN);
      `CHK(q[0], e)
   endtask

   // tol accepts one unit already elapsed since the start
   task automatic ld(input pstu_op_t op, input logic [6:0] idx, input logic [31:0] e, input logic tol);
      logic [31:0] v;
      cmd(op, idx, 1'b0);
      rd(ADR_ACC1);
      v = (tol && q === e - 32'h1) ? e : q;
      `CHK(v, e)
   endtask

   function automatic logic [31:0] raw(input logic [9:0] c, input logic [1:0] b);
      return {16'h0000, 2'b00, b, 2'b00, c};
   endfunction

   // value of three bcd digits
   function automatic logic [9:0] bcd_val(input logic [11:0] b);
      return 10'(b[11:8] * 10'h064 + b[7:4] * 10'h00A + b[3:0]);
   endfunction

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(4'h2);
      `CHK(q, 32'h0)
      st(7'h05, 1'b0);
      w1 = tw(12'h123, 2'h1);
      load(w1);
      load(tw(12'h045, 2'h0));
      rd(ADR_ACC2);
      `CHK(q, {16'h0000, w1})
      // lane 0 only: the upper byte of the operand must survive
      load(w1);
      host.xfer(1'b1, ADR_ACC1, 32'h0000FFFF, 4'h1, q);
      rd(ADR_ACC1);
      `CHK(q, {16'h0000, w1[15:8], 8'hFF})
      rd(ADR_ACC2);
      `CHK(q, {16'h0000, w1})
      // one-shot on the highest index
      w1 = tw(12'h003, 2'h0);
      load(w1);
      cmd(OP_ONE_SHOT, 7'h7F, 1'b1);
      st(7'h7F, 1'b1);
      ld(OP_LOAD_RAW, 7'h7F, raw(10'h003, 2'h0), 1'b1);
      rd(ADR_ACC2);
      `CHK(q, {16'h0000, w1})
      cmd(OP_ONE_SHOT, 7'h7F, 1'b0);
      st(7'h7F, 1'b0);
      load(tw(12'h002, 2'h0));
      cmd(OP_ONE_SHOT, 7'h7F, 1'b1);
      repeat (2000) @(posedge i_clk);
      st(7'h7F, 1'b0);
      ld(OP_LOAD_RAW, 7'h7F, raw(10'h000, 2'h0), 1'b0);
      cmd(OP_ONE_SHOT, 7'h7F, 1'b1);
      st(7'h7F, 1'b0);
      // lengthened pulse, then retrigger mid-count
      load(tw(12'h003, 2'h0));
      cmd(OP_LENGTHEN, 7'h01, 1'b1);
      cmd(OP_LENGTHEN, 7'h01, 1'b0);
      st(7'h01, 1'b1);
      repeat (700) @(posedge i_clk);
      st(7'h01, 1'b1);
      load(tw(12'h003, 2'h0));
      cmd(OP_LENGTHEN, 7'h01, 1'b1);
      ld(OP_LOAD_RAW, 7'h01, raw(10'h003, 2'h0), 1'b1);
      repeat (2500) @(posedge i_clk);
      st(7'h01, 1'b0);
      // bcd readout with the 1 s base
      load(tw(12'h123, 2'h2));
      cmd(OP_LENGTHEN, 7'h02, 1'b1);
      ld(OP_LOAD_BCD, 7'h02, {16'h0000, 4'h2, 12'h123}, 1'b1);
      // on-delay with the 100 ms base: 10 to 20 units of 500 cycles
      load(tw(12'h002, 2'h1));
      cmd(OP_ON_DELAY, 7'h03, 1'b1);
      repeat (3000) @(posedge i_clk);
      st(7'h03, 1'b0);
      repeat (8500) @(posedge i_clk);
      st(7'h03, 1'b1);
      cmd(OP_ON_DELAY, 7'h03, 1'b0);
      st(7'h03, 1'b0);
      // latched on-delay and reset
      load(tw(12'h002, 2'h0));
      cmd(OP_LATCHED, 7'h04, 1'b1);
      cmd(OP_LATCHED, 7'h04, 1'b0);
      repeat (2000) @(posedge i_clk);
      st(7'h04, 1'b1);
      cmd(OP_RESET, 7'h04, 1'b0);
      st(7'h04, 1'b1);
      cmd(OP_RESET, 7'h04, 1'b1);
      cmd(OP_NOP, 7'h04, 1'b1);
      st(7'h04, 1'b0);
      ld(OP_LOAD_RAW, 7'h04, raw(10'h002, 2'h0), 1'b0);
      // off-delay: held while high, runs after the fall
      load(tw(12'h002, 2'h0));
      cmd(OP_OFF_DELAY, 7'h05, 1'b1);
      st(7'h05, 1'b1);
      repeat (1500) @(posedge i_clk);
      ld(OP_LOAD_RAW, 7'h05, raw(10'h002, 2'h0), 1'b0);
      cmd(OP_OFF_DELAY, 7'h05, 1'b0);
      st(7'h05, 1'b1);
      repeat (2000) @(posedge i_clk);
      st(7'h05, 1'b0);
      // 10 s base: no unit can elapse within the run
      load(tw(12'h005, 2'h3));
      cmd(OP_LENGTHEN, 7'h06, 1'b1);
      repeat (1500) @(posedge i_clk);
      ld(OP_LOAD_RAW, 7'h06, raw(10'h005, 2'h3), 1'b0);
      st(7'h06, 1'b1);
      // random three-digit words on random timers, read back at once
      for (int n = 0; n < 8; n++) begin
         rv = rnd();
         dg = {4'(rv[11:8] % 4'hA), 4'(rv[7:4] % 4'hA), 4'(rv[3:0] % 4'hA)};
         load({rv[15:12], dg});
         cmd(OP_LENGTHEN, rv[22:16], 1'b0);
         cmd(OP_LENGTHEN, rv[22:16], 1'b1);
         ld(OP_LOAD_RAW, rv[22:16], raw(bcd_val(dg), rv[13:12]), 1'b1);
      end
      finish_test();
   end
endmodule
